// >>> design/opb_pkg.sv
package opb_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] RAM_LAST_ADDR      = 8'h7F;
   localparam logic [7:0] ADDR_ENABLE        = 8'h80;
   localparam logic [7:0] ADDR_LED_DRIVE     = 8'h8F;
   localparam logic [7:0] ADDR_LED_BOOST     = 8'h90;
   localparam logic [7:0] ADDR_MAIN_STATUS   = 8'h93;
   localparam logic [7:0] ADDR_QZ_CONFIG     = 8'hA0;
   localparam logic [7:0] ADDR_SYM_LOOPS     = 8'hA2;
   localparam logic [7:0] ADDR_SYM_OFF       = 8'hA3;
   localparam logic [7:0] ADDR_PKT_LOOPS     = 8'hA4;
   localparam logic [7:0] ADDR_PKT_OFF       = 8'hA5;
   localparam logic [7:0] ADDR_BIT_TIME      = 8'hA6;
   localparam logic [7:0] ADDR_SYM_LEN       = 8'hA7;
   localparam logic [7:0] ADDR_BURST_STATUS  = 8'hA8;
   localparam logic [7:0] ADDR_BURST_CLR     = 8'hE3;
   localparam logic [7:0] ADDR_ALL_CLR       = 8'hE7;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int BIT_POWER_ON     = 0;
   localparam int BIT_PROX_EN      = 2;
   localparam int BIT_GESTURE_EN   = 6;
   localparam int BIT_BURST_EN     = 7;
   localparam int BIT_BURST_IEN    = 5;
   localparam int BIT_STAT_DONE    = 3;
   localparam int BIT_BSTAT_DONE   = 1;
   localparam int BIT_BSTAT_BUSY   = 0;
   localparam int BIT_TIME_MSB     = 5;
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] RST_BIT_TIME = 8'h40;
   localparam logic [7:0] RST_BOOST    = 8'h01;

   // ------------------------------------------------------------------
   // Timing: one bit-time unit and one off-delay unit in cycles
   // ------------------------------------------------------------------
   localparam int BIT_UNIT_NS    = 1000;
   localparam int OFF_UNIT_NS    = 10000;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int BIT_UNIT_CYC   = BIT_UNIT_NS / CLK_PERIOD_NS;
   localparam int OFF_UNIT_CYC   = OFF_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_IDLE    = 3'b001,
      ST_SYMBOL  = 3'b010,
      ST_SYM_OFF = 3'b011,
      ST_PKT_OFF = 3'b100,
      ST_DONE    = 3'b101
   } opb_state_t;

endpackage

// >>> design/opb_burst_engine.sv
// Behaviour
// RULE_01: Power-on plus enable takes LED pin ownership.
// RULE_02: Length write or enable rise starts emission.
// RULE_03: Each RAM bit drives LED one bit time.
// RULE_04: Start address zero, MSB first, ascending.
// RULE_05: Length counts nibbles; zero emits one nibble.
// RULE_06: Length write sets busy, starts symbol.
// RULE_07: Symbol loops repeat, LED off between.
// RULE_08: Up to 256 symbol loops, then packets.
// RULE_09: Packets repeat symbol loops, packet off-delay.
// RULE_10: Zero packet count still runs packet delay.
// RULE_11: After last packet: flag, clear busy, idle.
// RULE_12: Done flag mirrored in main status.
// RULE_13: Interrupt enable drives interrupt pin.
// RULE_14: Clear registers clear done flag.
// RULE_15: Host keeps proximity and gesture disabled.
// RULE_16: Host programs registers before starting.
// RULE_17: RAM refused when powered off or busy.
// RULE_18: Gesture enable overwrites pattern RAM.
// RULE_19: Loop count N gives N+1 repetitions.
// RULE_20: Off-delays timed by loaded counters.
module opb_burst_engine
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       ext_led_req,
   output logic            led_driver_pin,
   output logic            burst_owns_led,
   output logic            irq_out
);

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [7:0] enable_q, led_drive_q, boost_q, qz_cfg_q;
   logic [7:0] sym_loops_q, sym_off_q, pkt_loops_q, pkt_off_q;
   logic [7:0] bit_time_q, sym_len_q, rdata_q;
   logic       done_q, busy_q, led_q, burst_en_prev_q;
   logic [7:0] ram [0:127];

   opb_pkg::opb_state_t state_q;
   logic [9:0]  bit_idx_q;
   // One bit wider than 16: the longest off-delay, 256 steps, needs it.
   logic [16:0] tick_q;
   logic [8:0]  sym_cnt_q, pkt_cnt_q;

   wire power_on   = enable_q[opb_pkg::BIT_POWER_ON];
   wire burst_en   = enable_q[opb_pkg::BIT_BURST_EN];
   wire gesture_en = enable_q[opb_pkg::BIT_GESTURE_EN];
   // RULE_01 pin ownership
   wire owns       = power_on & burst_en;
   wire active     = (state_q != opb_pkg::ST_OFF) &&
                     (state_q != opb_pkg::ST_IDLE);
   wire ram_sel    = reg_addr <= opb_pkg::RAM_LAST_ADDR;
   // RULE_17 RAM access gate
   wire ram_ok     = ram_sel & power_on & ~active;
   wire wr_len     = reg_wr & (reg_addr == opb_pkg::ADDR_SYM_LEN);
   // Triggers only count while idle, so a stray length write during a
   // burst cannot restart it half way.
   // RULE_02 start triggers
   wire start      = owns & ~active &
                     (wr_len | (burst_en & ~burst_en_prev_q));
   // RULE_14 flag clear
   wire clr_done   = (reg_wr | reg_rd) &
                     ((reg_addr == opb_pkg::ADDR_BURST_CLR) |
                      (reg_addr == opb_pkg::ADDR_ALL_CLR));

   // RULE_03 bit period from the bit-time field
   wire [16:0] bit_len = 17'((bit_time_q[opb_pkg::BIT_TIME_MSB:0] + 17'd1)
                         * opb_pkg::BIT_UNIT_CYC);
   // RULE_20 off-delay lengths
   wire [16:0] sym_off_len = 17'((sym_off_q + 17'd1) * opb_pkg::OFF_UNIT_CYC);
   wire [16:0] pkt_off_len = 17'((pkt_off_q + 17'd1) * opb_pkg::OFF_UNIT_CYC);
   // RULE_05 last bit index = 4*len + 3
   wire [9:0]  last_bit    = {sym_len_q, 2'b11};
   // RULE_04 MSB-first addressing
   wire [6:0]  ram_addr_b  = bit_idx_q[9:3];
   wire [2:0]  ram_bit_b   = 3'd7 - bit_idx_q[2:0];
   wire        pattern_bit = ram[ram_addr_b][ram_bit_b];
   wire        tick_end    = (tick_q == 17'd0);

   logic [7:0] main_status;
   logic [7:0] burst_stat;
   logic [7:0] rd_mux;

   // ------------------------------------------------------------------
   // Status packing and read selection
   // ------------------------------------------------------------------
   always_comb
   begin
      main_status = opb_pkg::RST_ZERO;
      burst_stat  = opb_pkg::RST_ZERO;
      main_status[opb_pkg::BIT_STAT_DONE] = done_q;
      burst_stat[opb_pkg::BIT_BSTAT_DONE] = done_q;
      burst_stat[opb_pkg::BIT_BSTAT_BUSY] = busy_q;
   end

   always_comb
   begin
      rd_mux = opb_pkg::RST_ZERO;
      unique case (reg_addr)
         opb_pkg::ADDR_ENABLE:       rd_mux = enable_q;
         opb_pkg::ADDR_LED_DRIVE:    rd_mux = led_drive_q;
         opb_pkg::ADDR_LED_BOOST:    rd_mux = boost_q;
         // RULE_12 status mirror
         opb_pkg::ADDR_MAIN_STATUS:  rd_mux = main_status;
         opb_pkg::ADDR_QZ_CONFIG:    rd_mux = qz_cfg_q;
         opb_pkg::ADDR_SYM_LOOPS:    rd_mux = sym_loops_q;
         opb_pkg::ADDR_SYM_OFF:      rd_mux = sym_off_q;
         opb_pkg::ADDR_PKT_LOOPS:    rd_mux = pkt_loops_q;
         opb_pkg::ADDR_PKT_OFF:      rd_mux = pkt_off_q;
         opb_pkg::ADDR_BIT_TIME:     rd_mux = bit_time_q;
         opb_pkg::ADDR_SYM_LEN:      rd_mux = sym_len_q;
         opb_pkg::ADDR_BURST_STATUS: rd_mux = burst_stat;
         default:
         begin
            if (ram_ok)
               rd_mux = ram[reg_addr[6:0]];
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         enable_q    <= opb_pkg::RST_ZERO;
         led_drive_q <= opb_pkg::RST_ZERO;
         boost_q     <= opb_pkg::RST_BOOST;
         qz_cfg_q    <= opb_pkg::RST_ZERO;
         sym_loops_q <= opb_pkg::RST_ZERO;
         sym_off_q   <= opb_pkg::RST_ZERO;
         pkt_loops_q <= opb_pkg::RST_ZERO;
         pkt_off_q   <= opb_pkg::RST_ZERO;
         bit_time_q  <= opb_pkg::RST_BIT_TIME;
         sym_len_q   <= opb_pkg::RST_ZERO;
         rdata_q     <= opb_pkg::RST_ZERO;
      end
      else
      begin
         if (reg_rd)
            rdata_q <= rd_mux;
         if (reg_wr)
         begin
            unique case (reg_addr)
               opb_pkg::ADDR_ENABLE:    enable_q    <= reg_wdata;
               opb_pkg::ADDR_LED_DRIVE: led_drive_q <= reg_wdata;
               opb_pkg::ADDR_LED_BOOST: boost_q     <= reg_wdata;
               opb_pkg::ADDR_QZ_CONFIG: qz_cfg_q    <= reg_wdata;
               opb_pkg::ADDR_SYM_LOOPS: sym_loops_q <= reg_wdata;
               opb_pkg::ADDR_SYM_OFF:   sym_off_q   <= reg_wdata;
               opb_pkg::ADDR_PKT_LOOPS: pkt_loops_q <= reg_wdata;
               opb_pkg::ADDR_PKT_OFF:   pkt_off_q   <= reg_wdata;
               opb_pkg::ADDR_BIT_TIME:  bit_time_q  <= reg_wdata;
               opb_pkg::ADDR_SYM_LEN:   sym_len_q   <= reg_wdata;
               default:
               begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Pattern RAM
   // ------------------------------------------------------------------
   // The RAM has no reset; its content persists while powered off unless gesture enable is set.
   always_ff @(posedge clk_sys)
   begin
      if (reg_wr && ram_ok)
         ram[reg_addr[6:0]] <= reg_wdata;
      // RULE_18 gesture storage reuse
      else if (gesture_en && !active)
         ram[bit_idx_q[6:0]] <= opb_pkg::RST_ZERO;
   end

   // ------------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------------
   opb_pkg::opb_state_t state_d;
   logic [9:0]          bit_idx_d;
   logic [16:0]         tick_d;
   logic [8:0]          sym_cnt_d;
   logic [8:0]          pkt_cnt_d;
   logic                busy_d;
   logic                done_d;
   logic                led_d;

   wire                 last_one = (bit_idx_q == last_bit);
   // RULE_19 N+1 loop counts
   wire                 last_sym = (sym_cnt_q == {1'b0, sym_loops_q});
   wire                 last_pkt = (pkt_cnt_q == {1'b0, pkt_loops_q});

   always_comb
   begin
      state_d   = state_q;
      bit_idx_d = bit_idx_q;
      tick_d    = tick_q;
      sym_cnt_d = sym_cnt_q;
      pkt_cnt_d = pkt_cnt_q;
      busy_d    = busy_q;
      led_d     = 1'b0;
      // A completion in the same cycle overrides this clear further down.
      done_d    = done_q & ~clr_done;
      if (!owns)
      begin
         // Losing ownership aborts a burst without raising the flag.
         state_d   = opb_pkg::ST_OFF;
         busy_d    = 1'b0;
         // Free-running walker used to scrub the RAM for gestures.
         bit_idx_d = 10'(bit_idx_q + 10'd1);
      end
      else
      begin
         unique case (state_q)
            opb_pkg::ST_OFF,
            opb_pkg::ST_IDLE:
            begin
               state_d = opb_pkg::ST_IDLE;
               if (start)
               begin
                  // RULE_06 busy and symbol start
                  busy_d    = 1'b1;
                  state_d   = opb_pkg::ST_SYMBOL;
                  bit_idx_d = 10'd0;
                  tick_d    = 17'(bit_len - 17'd1);
                  sym_cnt_d = 9'd0;
                  pkt_cnt_d = 9'd0;
               end
            end
            opb_pkg::ST_SYMBOL:
            begin
               // RULE_03 LED follows pattern bit
               led_d  = pattern_bit;
               tick_d = 17'(tick_q - 17'd1);
               if (tick_end && last_one)
               begin
                  state_d = opb_pkg::ST_SYM_OFF;
                  tick_d  = 17'(sym_off_len - 17'd1);
               end
               else if (tick_end)
               begin
                  bit_idx_d = 10'(bit_idx_q + 10'd1);
                  tick_d    = 17'(bit_len - 17'd1);
               end
            end
            opb_pkg::ST_SYM_OFF:
            begin
               // RULE_07 LED off between symbols
               tick_d = 17'(tick_q - 17'd1);
               if (tick_end && last_sym)
               begin
                  // RULE_08 move to packet phase
                  state_d = opb_pkg::ST_PKT_OFF;
                  tick_d  = 17'(pkt_off_len - 17'd1);
               end
               else if (tick_end)
               begin
                  sym_cnt_d = 9'(sym_cnt_q + 9'd1);
                  bit_idx_d = 10'd0;
                  tick_d    = 17'(bit_len - 17'd1);
                  state_d   = opb_pkg::ST_SYMBOL;
               end
            end
            opb_pkg::ST_PKT_OFF:
            begin
               // RULE_10 packet delay always runs
               tick_d = 17'(tick_q - 17'd1);
               // RULE_09 repeat whole symbol loop
               if (tick_end && last_pkt)
                  state_d = opb_pkg::ST_DONE;
               else if (tick_end)
               begin
                  pkt_cnt_d = 9'(pkt_cnt_q + 9'd1);
                  sym_cnt_d = 9'd0;
                  bit_idx_d = 10'd0;
                  tick_d    = 17'(bit_len - 17'd1);
                  state_d   = opb_pkg::ST_SYMBOL;
               end
            end
            opb_pkg::ST_DONE:
            begin
               // RULE_11 flag, busy clear, idle
               done_d  = 1'b1;
               busy_d  = 1'b0;
               state_d = opb_pkg::ST_IDLE;
            end
            default:
               state_d = opb_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_q         <= opb_pkg::ST_OFF;
         bit_idx_q       <= 10'd0;
         tick_q          <= 17'd0;
         sym_cnt_q       <= 9'd0;
         pkt_cnt_q       <= 9'd0;
         busy_q          <= 1'b0;
         done_q          <= 1'b0;
         led_q           <= 1'b0;
         burst_en_prev_q <= 1'b0;
      end
      else
      begin
         burst_en_prev_q <= owns;
         state_q         <= state_d;
         bit_idx_q       <= bit_idx_d;
         tick_q          <= tick_d;
         sym_cnt_q       <= sym_cnt_d;
         pkt_cnt_q       <= pkt_cnt_d;
         busy_q          <= busy_d;
         done_q          <= done_d;
         led_q           <= led_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign reg_rdata      = rdata_q;
   assign burst_owns_led = owns;
   // RULE_01 LED mux
   assign led_driver_pin = owns ? led_q : ext_led_req;
   // RULE_13 interrupt enable
   assign irq_out        = done_q & qz_cfg_q[opb_pkg::BIT_BURST_IEN];

endmodule

// >>> tb/opb_burst_engine_assertions.sv
module opb_burst_engine_checker
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       ext_led_req,
   input wire logic       led_driver_pin,
   input wire logic       burst_owns_led,
   input wire logic       irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Shadow of power-on and interrupt enable bits
   // ------------------------------------------------------------
   logic pon_q;
   logic ien_q;
   wire  en_wr = reg_wr && reg_addr == opb_pkg::ADDR_ENABLE;
   wire  qz_wr = reg_wr && reg_addr == opb_pkg::ADDR_QZ_CONFIG;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pon_q <= 1'b0;
         ien_q <= 1'b0;
      end
      else
      begin
         if (en_wr) pon_q <= reg_wdata[0];
         if (qz_wr) ien_q <= reg_wdata[5];
      end
   end
   sequence s_clr_access;
      (reg_wr || reg_rd) && (reg_addr == opb_pkg::ADDR_BURST_CLR ||
                             reg_addr == opb_pkg::ADDR_ALL_CLR);
   endsequence
   sequence s_own_wr;
      en_wr && reg_wdata[0] && reg_wdata[7];
   endsequence
   property p_mux;
      !burst_owns_led |-> led_driver_pin == ext_led_req;
   endproperty
   property p_own_on;
      s_own_wr |=> burst_owns_led;
   endproperty
   property p_own_off;
      en_wr && !(reg_wdata[0] && reg_wdata[7]) |=> !burst_owns_led;
   endproperty
   property p_irq_clear;
      s_clr_access |=> !irq_out;
   endproperty
   property p_irq_mask;
      !ien_q |-> !irq_out;
   endproperty
   property p_mirror;
      reg_rd && reg_addr == opb_pkg::ADDR_MAIN_STATUS && irq_out
         |=> reg_rdata[3];
   endproperty
   property p_ram_off;
      reg_rd && !reg_addr[7] && !pon_q |=> reg_rdata == 8'h00;
   endproperty
   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_mux: assert property (p_mux)
      else $error("led not following request");
   a_own_on: assert property (p_own_on)
      else $error("ownership not taken");
   a_own_off: assert property (p_own_off)
      else $error("ownership kept");
   a_irq_clear: assert property (p_irq_clear)
      else $error("irq not cleared");
   a_irq_mask: assert property (p_irq_mask)
      else $error("masked irq high");
   a_mirror: assert property (p_mirror)
      else $error("status mirror low");
   a_ram_off: assert property (p_ram_off)
      else $error("ram read unpowered");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved");
endmodule
bind opb_burst_engine opb_burst_engine_checker i_chk (.clk_sys(clk_sys),
   .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_led_req(ext_led_req),
   .led_driver_pin(led_driver_pin), .burst_owns_led(burst_owns_led),
   .irq_out(irq_out));

// >>> tb/opb_scanner_model.sv
// Scanner that counts light pulses and lit cycles seen on the LED.
module opb_scanner_model
(
   input  wire logic clk_sys,
   input  wire logic clr,
   input  wire logic led_driver_pin,
   output int        pulses,
   output int        lit_cycles
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_q;
   always @(posedge clk_sys)
   begin
      last_q <= led_driver_pin;
      if (clr)
      begin
         pulses <= 0;
         lit_cycles <= 0;
      end
      else
      begin
         if (led_driver_pin && !last_q) pulses <= pulses + 1;
         if (led_driver_pin) lit_cycles <= lit_cycles + 1;
      end
   end
endmodule

// >>> tb/opb_burst_engine_tb_top.sv
module opb_burst_engine_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PAT = 8'hA5;
   logic       clk_sys, rst, reg_wr, reg_rd, ext_led_req, clr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       led_driver_pin, burst_owns_led, irq_out;
   int         pulses, lit_cycles, cyc = 0, mismatches = 0, total_checks = 0;
   opb_burst_engine i_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .ext_led_req(ext_led_req),
      .led_driver_pin(led_driver_pin), .burst_owns_led(burst_owns_led),
      .irq_out(irq_out));
   opb_scanner_model i_scan (.clk_sys(clk_sys), .clr(clr),
      .led_driver_pin(led_driver_pin), .pulses(pulses),
      .lit_cycles(lit_cycles));
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;
   // ------------------------------------------------------------
   // Access and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      total_checks++;
      if (got != exp)
      begin
         mismatches++;
         $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, e);
   endtask
   task automatic wait_cyc(input int n);
      while (cyc < n) @(negedge clk_sys);
   endtask
   // Starts a burst, checks the first symbol bit by bit, the run length and
   // what the scanner saw; the request line is raised to prove it is ignored.
   task automatic burst(input logic [7:0] a, input logic [7:0] d, input int t,
                        input int p, input int nb, input int np, input int lit);
      int t0;
      ext_led_req = 1'b0;
      clr = 1'b1;
      wr(a, d);
      clr = 1'b0;
      t0 = cyc;
      ext_led_req = 1'b1;
      rd(opb_pkg::ADDR_BURST_STATUS, 8'h01);
      rd(8'h00, 8'h00);
      for (int k = 0; k < nb; k++)
      begin
         wait_cyc(t0 + 2 + k * p + p / 2);
         chk({7'h0, led_driver_pin}, {7'h0, PAT[7 - k]});
      end
      wait_cyc(t0 + t - 20);
      rd(opb_pkg::ADDR_BURST_STATUS, 8'h01);
      wait_cyc(t0 + t + 10);
      rd(opb_pkg::ADDR_BURST_STATUS, 8'h02);
      chk_cnt(pulses, np);
      chk_cnt(lit_cycles, lit);
      $display("test burst done at %0t", $time);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      summarize();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      ext_led_req = 1'b0;
      clr = 1'b0;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      rd(opb_pkg::ADDR_LED_BOOST, 8'h01);
      rd(opb_pkg::ADDR_BIT_TIME, 8'h40);
      rd(opb_pkg::ADDR_BURST_STATUS, 8'h00);
      rd(opb_pkg::ADDR_MAIN_STATUS, 8'h00);
      rd(8'hB0, 8'h00);
      $display("test reset values done");
      wr(opb_pkg::ADDR_ENABLE, 8'h01);
      wr(8'h00, PAT);
      ext_led_req = 1'b1;
      wr(opb_pkg::ADDR_ENABLE, 8'h00);
      wr(8'h00, 8'h3C);
      rd(8'h00, 8'h00);
      chk({7'h0, led_driver_pin}, 8'h01);
      chk({7'h0, burst_owns_led}, 8'h00);
      wr(opb_pkg::ADDR_ENABLE, 8'h01);
      rd(8'h00, PAT);
      $display("test ram access done");
      burst(opb_pkg::ADDR_ENABLE, 8'h81, 1200, 50, 4, 2, 100);
      chk({7'h0, led_driver_pin}, 8'h00);
      chk({7'h0, burst_owns_led}, 8'h01);
      rd(opb_pkg::ADDR_MAIN_STATUS, 8'h08);
      chk({7'h0, irq_out}, 8'h00);
      wr(opb_pkg::ADDR_BURST_CLR, 8'h00);
      rd(opb_pkg::ADDR_BURST_STATUS, 8'h00);
      wr(opb_pkg::ADDR_SYM_LOOPS, 8'h01);
      wr(opb_pkg::ADDR_BIT_TIME, 8'h00);
      rd(opb_pkg::ADDR_BIT_TIME, 8'h00);
      burst(opb_pkg::ADDR_SYM_LEN, 8'h01, 2300, 50, 8, 8, 400);
      wr(opb_pkg::ADDR_QZ_CONFIG, 8'h20);
      chk({7'h0, irq_out}, 8'h01);
      rd(opb_pkg::ADDR_MAIN_STATUS, 8'h08);
      wr(opb_pkg::ADDR_ALL_CLR, 8'h00);
      chk({7'h0, irq_out}, 8'h00);
      wr(opb_pkg::ADDR_SYM_LOOPS, 8'h00);
      wr(opb_pkg::ADDR_SYM_OFF, 8'h01);
      wr(opb_pkg::ADDR_PKT_LOOPS, 8'h01);
      wr(opb_pkg::ADDR_BIT_TIME, 8'h01);
      burst(opb_pkg::ADDR_SYM_LEN, 8'h00, 3800, 100, 4, 4, 400);
      chk({7'h0, irq_out}, 8'h01);
      wr(opb_pkg::ADDR_BURST_CLR, 8'h00);
      chk({7'h0, irq_out}, 8'h00);
      wr(opb_pkg::ADDR_ENABLE, 8'h41);
      repeat (300) @(negedge clk_sys);
      rd(8'h00, 8'h00);
      $display("test gesture scrub done");
      summarize();
   end
endmodule
